/* design/nvsq_host.sv */
// Host-side controller driving the nonvolatile SRAM over its parallel pins
// ==========================================================================
// What this block does
// - Never hold write when powerup reload ends
// - Save: five key reads then 0x0FC0
// - Reload: five key reads then 0x0C63
// - Write strobe stays high for sequences
`timescale 1ns/1ps
module nvsq_host #(
    parameter int SAVE_CYCLES   = nvsq_pkg::SAVE_CYC,
    parameter int RELOAD_CYCLES = nvsq_pkg::RELOAD_CYC,
    parameter int PUP_CYCLES    = nvsq_pkg::PUP_CYC
) (
    input  wire logic                         sys_clk_in,
    input  wire logic                         reset_in,
    input  wire logic                         clk_en_in,
    input  wire logic                         req_valid_in,
    input  wire nvsq_pkg::nvsq_req_t          req_in,
    input  wire logic                         holdup_low_in,
    input  wire logic [nvsq_pkg::DATA_W-1:0]  data_lines_in,
    output logic                              req_ready_out,
    output logic                              rsp_valid_out,
    output logic [nvsq_pkg::DATA_W-1:0]       rsp_data_out,
    output logic                              rsp_refused_out,
    output nvsq_pkg::nvsq_bus_t               bus_out,
    output logic [nvsq_pkg::DATA_W-1:0]       data_lines_out,
    output logic                              data_lines_oe_out
);
    typedef enum logic [2:0] {
        NVSQ_S_PUP    = 3'b000,
        NVSQ_S_IDLE   = 3'b001,
        NVSQ_S_SETUP  = 3'b010,
        NVSQ_S_STROBE = 3'b011,
        NVSQ_S_HOLD   = 3'b100,
        NVSQ_S_BUSY   = 3'b101
    } nvsq_state_t;

    // Phase counter, sequence step and the latched request
    nvsq_state_t        state;
    nvsq_pkg::nvsq_op_t op;
    logic [3:0]         phase;
    logic [2:0]         step;
    logic [31:0]        wait_cnt;
    logic [nvsq_pkg::ADDR_W-1:0] cur_addr;
    logic [nvsq_pkg::DATA_W-1:0] cur_wdata;

    // ==========================================================================
    // Sequence helpers
    // Address of sequence step 0..5; top bit driven low, device ignores it
    function automatic logic [nvsq_pkg::ADDR_W-1:0] seq_addr(
        input logic [2:0] idx, input nvsq_pkg::nvsq_op_t o);
        logic [13:0] a;
        a = nvsq_pkg::SEQ_A1;
        case (idx)
            3'h0:    a = nvsq_pkg::SEQ_A1;
            3'h1:    a = nvsq_pkg::SEQ_A2;
            3'h2:    a = nvsq_pkg::SEQ_A3;
            3'h3:    a = nvsq_pkg::SEQ_A4;
            3'h4:    a = nvsq_pkg::SEQ_A5;
            default: a = (o == nvsq_pkg::NVSQ_OP_SAVE) ? nvsq_pkg::SEQ_SAVE
                                                       : nvsq_pkg::SEQ_LOAD;
        endcase
        return {1'b0, a};
    endfunction : seq_addr

    // Save and reload are the two operations that become six-read sequences
    function automatic logic is_seq(input nvsq_pkg::nvsq_op_t o);
        return o == nvsq_pkg::NVSQ_OP_SAVE || o == nvsq_pkg::NVSQ_OP_RELOAD;
    endfunction : is_seq

    // ==========================================================================
    // Sequencing
    // One request at a time; a save or reload runs its six reads back to back
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            state           <= NVSQ_S_PUP;
            op              <= nvsq_pkg::NVSQ_OP_READ;
            phase           <= 4'h0;
            step            <= 3'h0;
            wait_cnt        <= 32'h0;
            cur_addr        <= '0;
            cur_wdata       <= '0;
            req_ready_out   <= 1'b0;
            rsp_valid_out   <= 1'b0;
            rsp_refused_out <= 1'b0;
            rsp_data_out    <= '0;
        end else if (clk_en_in) begin
            rsp_valid_out   <= 1'b0;
            rsp_refused_out <= 1'b0;
            case (state)
                NVSQ_S_PUP: begin
                    // Bus held deselected, strobe high, for the whole reload
                    // Ready stays low, so no request is taken before the device can serve it
                    if (wait_cnt >= 32'(PUP_CYCLES - 1)) begin
                        state         <= NVSQ_S_IDLE;
                        wait_cnt      <= 32'h0;
                        req_ready_out <= 1'b1;
                    end else begin
                        wait_cnt <= wait_cnt + 32'h1;
                    end
                end
                NVSQ_S_IDLE: begin
                    if (req_valid_in) begin
                        req_ready_out <= 1'b0;
                        // Low holdup: device would drop it, so refuse here
                        if (holdup_low_in && (req_in.op == nvsq_pkg::NVSQ_OP_WRITE ||
                                              req_in.op == nvsq_pkg::NVSQ_OP_SAVE)) begin
                            rsp_valid_out   <= 1'b1;
                            rsp_refused_out <= 1'b1;
                            req_ready_out   <= 1'b1;
                        end else begin
                            // Saves go out whether or not anything was written; only the
                            // device's own power-loss save is skipped when nothing changed
                            op        <= req_in.op;
                            step      <= 3'h0;
                            cur_wdata <= req_in.wdata;
                            cur_addr  <= is_seq(req_in.op) ? seq_addr(3'h0, req_in.op)
                                                           : req_in.addr;
                            phase     <= 4'h0;
                            state     <= NVSQ_S_SETUP;
                        end
                    end
                end
                NVSQ_S_SETUP: begin
                    if (phase == nvsq_pkg::SETUP_CYC - 4'h1) begin
                        phase <= 4'h0;
                        state <= NVSQ_S_STROBE;
                    end else begin
                        phase <= phase + 4'h1;
                    end
                end
                NVSQ_S_STROBE: begin
                    if (phase == nvsq_pkg::STROBE_CYC - 4'h1) begin
                        phase <= 4'h0;
                        state <= NVSQ_S_HOLD;
                        // Last strobe cycle: the device has driven the lines for one cycle
                        if (op == nvsq_pkg::NVSQ_OP_READ) begin
                            rsp_data_out <= data_lines_in;
                        end
                    end else begin
                        phase <= phase + 4'h1;
                    end
                end
                NVSQ_S_HOLD: begin
                    if (phase == nvsq_pkg::HOLD_CYC - 4'h1) begin
                        phase <= 4'h0;
                        // Next step follows at once: nothing may intervene
                        if (is_seq(op) && step != 3'h5) begin
                            step     <= step + 3'h1;
                            cur_addr <= seq_addr(step + 3'h1, op);
                            state    <= NVSQ_S_SETUP;
                        end else if (is_seq(op)) begin
                            state    <= NVSQ_S_BUSY;
                            wait_cnt <= 32'h0;
                        end else begin
                            rsp_valid_out <= 1'b1;
                            req_ready_out <= 1'b1;
                            state         <= NVSQ_S_IDLE;
                        end
                    end else begin
                        phase <= phase + 4'h1;
                    end
                end
                NVSQ_S_BUSY: begin
                    // Device ignores the bus until its busy time is over
                    // Erase and program, or clear and copy, run inside the device meanwhile
                    if (wait_cnt >= 32'((op == nvsq_pkg::NVSQ_OP_SAVE) ? SAVE_CYCLES - 1
                                                                  : RELOAD_CYCLES - 1)) begin
                        rsp_valid_out <= 1'b1;
                        req_ready_out <= 1'b1;
                        state         <= NVSQ_S_IDLE;
                    end else begin
                        wait_cnt <= wait_cnt + 32'h1;
                    end
                end
                default: state <= NVSQ_S_PUP;
            endcase
        end
    end

    // ==========================================================================
    // Pin drive, all registered
    // Write data is driven from strobe through hold so it outlasts the strobe edge,
    // and pins follow the state one cycle later
    logic strobe_now;
    logic wr_drive;
    assign strobe_now = (state == NVSQ_S_STROBE);
    assign wr_drive   = (state == NVSQ_S_STROBE || state == NVSQ_S_HOLD) &&
                        op == nvsq_pkg::NVSQ_OP_WRITE;

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            bus_out           <= '{chip_sel_n: 1'b1, write_n: 1'b1, out_drive_n: 1'b1,
                                   address_lines: '0};
            data_lines_out    <= '0;
            data_lines_oe_out <= 1'b0;
        end else if (clk_en_in) begin
            bus_out.address_lines <= cur_addr;
            data_lines_out        <= cur_wdata;
            // Select low only in the strobe phase, after the address has settled for
            // two cycles, so select alone times each sequence read; plain reads pulse output drive with it
            bus_out.chip_sel_n  <= !strobe_now;
            bus_out.write_n     <= !(strobe_now && op == nvsq_pkg::NVSQ_OP_WRITE);
            bus_out.out_drive_n <= !(strobe_now && op == nvsq_pkg::NVSQ_OP_READ);
            data_lines_oe_out   <= wr_drive;
        end
    end
endmodule : nvsq_host

/* design/nvsq_pkg.sv */
// Package for the nonvolatile save/reload host sequencer
package nvsq_pkg;
    localparam int        ADDR_W      = 15;
    localparam int        DATA_W      = 8;
    localparam int        MATCH_W     = 14;
    localparam logic [13:0] SEQ_A1    = 14'h0e38;
    localparam logic [13:0] SEQ_A2    = 14'h31c7;
    localparam logic [13:0] SEQ_A3    = 14'h03e0;
    localparam logic [13:0] SEQ_A4    = 14'h3c1f;
    localparam logic [13:0] SEQ_A5    = 14'h303f;
    localparam logic [13:0] SEQ_SAVE  = 14'h0fc0;
    localparam logic [13:0] SEQ_LOAD  = 14'h0c63;
    localparam int        CLK_MHZ     = 40;
    // Cycle phase lengths on the parallel bus (clock cycles)
    localparam logic [3:0] SETUP_CYC  = 4'h2;
    localparam logic [3:0] STROBE_CYC = 4'h3;
    localparam logic [3:0] HOLD_CYC   = 4'h2;
    // Save and reload busy times in microseconds
    localparam int        SAVE_TIME_US   = 10000;
    localparam int        RELOAD_TIME_US = 20;
    localparam int        POWERUP_RELOAD_TIME_US = 20000;
    localparam int        SAVE_CYC    = SAVE_TIME_US * CLK_MHZ;
    localparam int        RELOAD_CYC  = RELOAD_TIME_US * CLK_MHZ;
    localparam int        PUP_CYC     = POWERUP_RELOAD_TIME_US * CLK_MHZ;

    typedef enum logic [1:0] {
        NVSQ_OP_READ   = 2'b00,
        NVSQ_OP_WRITE  = 2'b01,
        NVSQ_OP_SAVE   = 2'b10,
        NVSQ_OP_RELOAD = 2'b11
    } nvsq_op_t;

    typedef struct packed {
        nvsq_op_t          op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } nvsq_req_t;

    typedef struct packed {
        logic              chip_sel_n;
        logic              write_n;
        logic              out_drive_n;
        logic [ADDR_W-1:0] address_lines;
    } nvsq_bus_t;
endpackage : nvsq_pkg

/* verification/nvsq_dev_model.sv */
// Behavioural model of the nonvolatile SRAM at the far side of the host
`timescale 1ns/1ps
module nvsq_dev_model #(
    parameter int PUP    = 40,
    parameter int SAVE   = 50,
    parameter int RELOAD = 20
) (
    input  wire logic                clk_in,
    input  wire logic                reset_in,
    input  wire logic                holdup_low_in,
    input  wire nvsq_pkg::nvsq_bus_t bus_in,
    input  wire logic [7:0]          data_in,
    output logic [7:0]               data_out,
    output int                       saves,
    output int                       loads,
    output int                       viol
);
    logic [7:0]  mem [0:32767];
    logic [7:0]  nv  [0:32767];
    logic [13:0] key [0:4] = '{14'h0e38, 14'h31c7, 14'h03e0, 14'h3c1f, 14'h303f};
    logic [13:0] a;
    logic        cs_q = 1'b1;
    int          step;
    int          busy;
    assign a = bus_in.address_lines[13:0];
    initial begin
        {saves, loads, viol, step} = '0;
        data_out = 8'h00;
        for (int i = 0; i < 32768; i++) begin
            mem[i] = i[7:0] ^ 8'ha5;
            nv[i] = 8'h00;
        end
    end
    // Undriven lines toggle so that stale data can never pass for a read
    always @(posedge clk_in) begin
        cs_q <= bus_in.chip_sel_n;
        if (!bus_in.chip_sel_n && !bus_in.out_drive_n && busy == 0) begin
            data_out <= mem[bus_in.address_lines];
        end else begin
            data_out <= ~data_out;
        end
        if (reset_in) begin
            busy <= PUP;
            step <= 0;
        end else if (busy > 0) begin
            busy <= busy - 1;
            // A select begun before the busy time may finish; a new one may not
            if ((!bus_in.chip_sel_n && cs_q) || (busy == 1 && !bus_in.write_n)) begin
                viol <= viol + 1;
            end
        end else if (!bus_in.chip_sel_n && !bus_in.write_n) begin
            step <= 0;
            if (!holdup_low_in) mem[bus_in.address_lines] <= data_in;
        end else if (!bus_in.chip_sel_n && cs_q) begin
            step <= (a == key[0]) ? 1 : 0;
            if (step == 5 && a == 14'h0fc0 && !holdup_low_in) begin
                nv <= mem;
                saves <= saves + 1;
                busy <= SAVE;
            end else if (step == 5 && a == 14'h0c63) begin
                mem <= nv;
                loads <= loads + 1;
                busy <= RELOAD;
            end else if (step < 5 && a == key[step]) begin
                step <= step + 1;
            end
        end
    end
endmodule : nvsq_dev_model

/* verification/nvsq_host_checker.sv */
// Port assertions for the host sequencer
`timescale 1ns/1ps
module nvsq_host_checker (
    input wire logic                sys_clk_in,
    input wire logic                reset_in,
    input wire logic                clk_en_in,
    input wire logic                req_valid_in,
    input wire nvsq_pkg::nvsq_req_t req_in,
    input wire logic                holdup_low_in,
    input wire logic                req_ready_out,
    input wire logic                rsp_valid_out,
    input wire logic                rsp_refused_out,
    input wire nvsq_pkg::nvsq_bus_t bus_out,
    input wire logic                data_lines_oe_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);
    logic take;
    logic cs;
    logic wn;
    assign take = clk_en_in && req_ready_out && req_valid_in;
    assign cs = bus_out.chip_sel_n;
    assign wn = bus_out.write_n;
    a_read_latency: assert property (
        take && req_in.op == nvsq_pkg::NVSQ_OP_READ |-> ##8 rsp_valid_out && !rsp_refused_out)
        else $error("read answer late");
    // Write and save are the two codes whose bits differ
    a_low_refused: assert property (
        take && holdup_low_in && ^req_in.op |=> rsp_valid_out && rsp_refused_out)
        else $error("no refusal");
    a_refuse_quiet: assert property (rsp_refused_out |-> cs && wn)
        else $error("bus moved on refusal");
    a_strobe_width: assert property ($fell(cs) |-> !cs [*3] ##1 cs)
        else $error("select width");
    a_addr_setup: assert property ($fell(cs) |-> $stable(bus_out.address_lines))
        else $error("address moved");
    a_read_shape: assert property (!cs && !bus_out.out_drive_n |-> wn && !data_lines_oe_out)
        else $error("read with write");
    a_write_shape: assert property (!wn |-> !cs && data_lines_oe_out)
        else $error("write shape");
    a_seq_no_write: assert property (take && req_in.op[1] |=> (wn && !data_lines_oe_out) [*8])
        else $error("write in sequence");
    a_busy_select: assert property (!cs |-> !req_ready_out)
        else $error("ready while selected");
    c_save: cover property (take && req_in.op == nvsq_pkg::NVSQ_OP_SAVE);
    c_reload: cover property (take && req_in.op == nvsq_pkg::NVSQ_OP_RELOAD);
    c_refused: cover property (rsp_refused_out);
endmodule : nvsq_host_checker
bind nvsq_host nvsq_host_checker chk (.sys_clk_in, .reset_in, .clk_en_in, .req_valid_in,
    .req_in, .holdup_low_in, .req_ready_out, .rsp_valid_out, .rsp_refused_out, .bus_out,
    .data_lines_oe_out);

/* verification/tb_nvsq_host.sv */
// Self-checking bench for the nonvolatile save/reload host sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
    $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb_nvsq_host;
    localparam int PUP = 40;
    localparam nvsq_pkg::nvsq_op_t op_rd = nvsq_pkg::NVSQ_OP_READ;
    localparam nvsq_pkg::nvsq_op_t op_wr = nvsq_pkg::NVSQ_OP_WRITE;
    localparam nvsq_pkg::nvsq_op_t op_sv = nvsq_pkg::NVSQ_OP_SAVE;
    localparam nvsq_pkg::nvsq_op_t op_ld = nvsq_pkg::NVSQ_OP_RELOAD;
    logic                clk = 0;
    logic                rst = 1;
    logic                valid = 0;
    logic                hold = 0;
    logic                ready, rv, rf_o, oe, rf;
    nvsq_pkg::nvsq_req_t req = '0;
    nvsq_pkg::nvsq_bus_t bus;
    logic [7:0]          dq_in, dq_out, rdata, q;
    int                  err_total = 0, n_checks = 0, n, saves, loads, viol;
    nvsq_host #(.SAVE_CYCLES(50), .RELOAD_CYCLES(20), .PUP_CYCLES(PUP)) dut (
        .sys_clk_in(clk), .reset_in(rst), .clk_en_in(1'b1), .req_valid_in(valid),
        .req_in(req), .holdup_low_in(hold), .data_lines_in(dq_in), .req_ready_out(ready),
        .rsp_valid_out(rv), .rsp_data_out(rdata), .rsp_refused_out(rf_o), .bus_out(bus),
        .data_lines_out(dq_out), .data_lines_oe_out(oe));
    nvsq_dev_model #(.PUP(PUP), .SAVE(50), .RELOAD(20)) model (.clk_in(clk), .reset_in(rst),
        .holdup_low_in(hold), .bus_in(bus), .data_in(oe ? dq_out : ~dq_in), .data_out(dq_in),
        .saves(saves), .loads(loads), .viol(viol));
    initial forever #12.5 clk = ~clk;
    // Requests are raised only at a falling edge where ready is already settled high
    task automatic do_op(input nvsq_pkg::nvsq_op_t o, input logic [14:0] a, input logic [7:0] d);
        n = 0;
        while (ready !== 1'b1 && n < 2000) begin @(negedge clk); n++; end
        valid = 1;
        req = '{op: o, addr: a, wdata: d};
        @(negedge clk);
        valid = 0;
        while (rv !== 1'b1 && n < 2000) begin @(negedge clk); n++; end
        q = rdata;
        rf = rf_o;
        if (n >= 2000) begin
            err_total++;
            $display("[ERR] %0t no answer from host", $time);
        end
        // Let an edge pass so a following request never re-raises valid at once
        @(negedge clk);
    endtask : do_op
    task automatic t_power;
        repeat (10) @(negedge clk);
        rst = 0;
        n = 0;
        while (ready !== 1'b1 && n < 1000) begin @(negedge clk); n++; end
        `CHK(n >= PUP, 1'b1)
    endtask : t_power
    task automatic t_rw;
        do_op(op_wr, 15'h4e38, 8'h3c);
        do_op(op_rd, 15'h4e38, 8'h00);
        `CHK(q, 8'h3c)
        do_op(op_rd, 15'h0e38, 8'h00);
        `CHK(q, 8'h9d)
    endtask : t_rw
    task automatic t_save;
        do_op(op_wr, 15'h0100, 8'h11);
        do_op(op_sv, 15'h0000, 8'h00);
        `CHK(saves, 1)
        do_op(op_wr, 15'h0100, 8'h22);
        repeat (2) begin
            do_op(op_ld, 15'h0000, 8'h00);
            do_op(op_rd, 15'h0100, 8'h00);
            `CHK(q, 8'h11)
        end
        `CHK(loads, 2)
        do_op(op_sv, 15'h0000, 8'h00);
        `CHK(saves, 2)
    endtask : t_save
    task automatic t_hold;
        hold = 1;
        do_op(op_wr, 15'h0100, 8'h77);
        `CHK(rf, 1'b1)
        do_op(op_sv, 15'h0000, 8'h00);
        `CHK(rf, 1'b1)
        do_op(op_rd, 15'h0100, 8'h00);
        `CHK(q, 8'h11)
        `CHK(saves, 2)
        hold = 0;
        `CHK(viol, 0)
    endtask : t_hold
    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    initial begin
        #125000;
        err_total++;
        report_and_stop();
    end
    initial begin
        t_power();
        t_rw();
        t_save();
        t_hold();
        report_and_stop();
    end
endmodule : tb_nvsq_host
